// >>> common/supervisor_pkg.sv
// package of constants for the serial link and input supervisor.
// assumes a 250 MHz system clock; all cycle counts derive from it.
package supervisor_pkg;
  // system clock rate
  localparam int unsigned CLK_KHZ        = 250_000;
  // watchdog timeouts in ms, for period select 0 and 1
  localparam int unsigned T_WD0_MS       = 32;
  localparam int unsigned T_WD1_MS       = 128;
  localparam int unsigned WD0_CYC        = T_WD0_MS * CLK_KHZ;
  localparam int unsigned WD1_CYC        = T_WD1_MS * CLK_KHZ;
  // deglitch times: inputs and reset in us, timebase in ns
  localparam int unsigned T_IN_DGL_US    = 200;
  localparam int unsigned T_RST_DGL_US   = 10;
  localparam int unsigned T_CLK_DGL_NS   = 2000;
  localparam int unsigned IN_DGL_CYC     = T_IN_DGL_US * CLK_KHZ / 1000;
  localparam int unsigned RST_DGL_CYC    = T_RST_DGL_US * CLK_KHZ / 1000;
  localparam int unsigned CLK_DGL_CYC    = T_CLK_DGL_NS * CLK_KHZ / 1_000_000;
  // low timebase frequency limit in Hz, as a period in cycles
  localparam int unsigned F_CLK_LOW_HZ   = 100;
  localparam int unsigned CLK_LOW_CYC    = CLK_KHZ * 1000 / F_CLK_LOW_HZ;
  // frame length must be a whole number of words of this many bits
  localparam int unsigned WORD_BITS      = 16;
  // incoming word fields
  localparam int unsigned TOGGLE_POS     = 15;
  localparam int unsigned ADDR_HI        = 14;
  localparam int unsigned ADDR_LO        = 12;
  localparam int unsigned CH6_POS        = 5;
  localparam logic [2:0]  ADDR_INPUT     = 3'h0;
  localparam logic [2:0]  ADDR_QSTAT     = 3'h1;
  // outgoing device status word: address 7 and flag positions
  localparam logic [2:0]  ADDR_DSTAT     = 3'h7;
  localparam int unsigned FF_POS         = 0;
  localparam int unsigned LFF_POS        = 1;
  localparam int unsigned CKF_POS        = 2;
  // operating modes
  typedef enum logic [1:0] {
    MODE_SLEEP  = 2'b00,
    MODE_NORMAL = 2'b01,
    MODE_FAIL   = 2'b10
  } mode_t;
endpackage

// >>> verilog/spi_link_and_input_supervisor.sv
// serial link watchdog, frame checks, input deglitchers, timebase clock
// supervision and external switch drive gating.
// assumes sclk_i stops outside frames and cs_n_i frames every message.
`timescale 1ns/1ps
`default_nettype none

// counter deglitcher: output moves after raw has differed for N cycles; with SYM clear a high raw passes at once
module deglitch #(
  parameter int unsigned N    = 500,
  parameter int unsigned W    = 16,
  parameter bit          SYM  = 1'b1,
  parameter bit          INIT = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic raw_i,
  output logic      filt_o
);
  logic [W-1:0] cnt; // cycles raw has differed from the output

  if (N < 1 || N > (2**W)) begin : g_bad
    $error("deglitch count does not fit its counter");
  end

  // reload on any return to the output level, commit after N cycles
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt    <= '0;
      filt_o <= INIT;
    end else if (raw_i == filt_o) begin
      cnt <= '0;
    end else if ((!SYM && raw_i) || cnt == W'(N - 1)) begin
      cnt    <= '0;
      filt_o <= raw_i;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule // deglitch

// Notes on behaviour
// - any link fault forces Fail mode
// - unchanged toggle bit is a link fault
// - no good message within timeout faults
// - frame clocks not multiple of sixteen fault
// - link failure flag in status word seven
// - flag holds in Fail, clears leaving it
// - fail-force and direct inputs deglitched symmetrically
// - filtered fail-force high forces Fail mode
// - in Fail mode, filtered direct input controls its channel
// - reset pin filtered on falling edge only
// - timebase deglitched; too fast means failure
// - slow timebase detection starts at reset release
// - failed timebase: Normal outputs follow channel requests
// - clock fail latched until gone and read
// - switch drive follows channel six in Normal
// - switch drive off in Sleep and Fail
// - Fail mode: outputs follow filtered direct inputs
// - fail-force state readable in status seven
module spi_link_and_input_supervisor
  import supervisor_pkg::*;
#(
  parameter int unsigned NCH      = 4,
  parameter int unsigned WD0      = WD0_CYC,
  parameter int unsigned WD1      = WD1_CYC,
  parameter int unsigned IN_DGL   = IN_DGL_CYC,
  parameter int unsigned CLK_LOW  = CLK_LOW_CYC
) (
  // system clock and reset
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  // serial link, slave side
  input  wire logic           sclk_i,
  input  wire logic           cs_n_i,
  input  wire logic           mosi_i,
  output logic                miso_o,
  output logic                miso_oe_n_o,
  // pins
  input  wire logic           fail_force_i,
  input  wire logic [NCH-1:0] direct_channel_inputs_i,
  input  wire logic           reset_pin_n_i,
  input  wire logic           timebase_clk_i,
  // control from the rest of the device
  input  wire logic           watchdog_period_select_i,
  input  wire logic [NCH-1:0] channel_on_request_i,
  input  wire logic [NCH-1:0] pwm_i,
  // outputs
  output logic [NCH-1:0]      channel_out_o,
  output logic                external_switch_drive_o,
  output logic [1:0]          mode_o,
  output logic                link_failure_flag_o,
  output logic                filtered_fail_force_o,
  output logic                clock_fail_o
);
  import supervisor_pkg::*;

  if (NCH < 1 || WD0 < 2 || WD1 < 2 || IN_DGL < 1 || CLK_LOW < 2) begin : g_bad
    $error("supervisor parameter out of range");
  end

  // ---------------- link clock domain ----------------
  logic                 frame_open;  // set by first clock, cleared by chip select
  logic [7:0]           lk_cnt;      // clocks seen in this frame, wraps by 256
  logic [WORD_BITS-1:0] lk_shift;    // last word shifted in, msb first
  logic [2:0]           st_s1;       // status into link domain, first stage
  logic [2:0]           st_s2;       // status into link domain, second stage
  logic [WORD_BITS-1:0] st_word;     // outgoing device status word

  // chip select high clears the frame flag without a clock edge
  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      frame_open <= 1'b0;
    end else begin
      frame_open <= 1'b1;
    end
  end

  // count and shift; the values stay put after the frame for the other side
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lk_cnt   <= '0;
      lk_shift <= '0;
    end else begin
      lk_cnt   <= frame_open ? lk_cnt + 1'b1 : 8'h01;
      lk_shift <= {lk_shift[WORD_BITS-2:0], mosi_i};
    end
  end

  // status levels cross by two flops; only advance while the link clocks
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_s1 <= '0;
      st_s2 <= '0;
    end else begin
      st_s1 <= {clock_fail_o, link_failure_flag_o, filtered_fail_force_o};
      st_s2 <= st_s1;
    end
  end

  // bit 15 is zero so the idle line after a whole word is already correct
  always_comb begin
    st_word          = '0;
    st_word[ADDR_HI:ADDR_LO] = ADDR_DSTAT;
    st_word[FF_POS]  = st_s2[0];
    st_word[LFF_POS] = st_s2[1];
    st_word[CKF_POS] = st_s2[2];
  end

  // data out changes on the falling edge, for the host's rising edge
  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      miso_o <= 1'b0;
    end else begin
      miso_o <= st_word[4'hf - lk_cnt[3:0]];
    end
  end

  // ---------------- system clock domain ----------------
  // pin synchronisers: the first stage feeds only the second
  localparam int unsigned NS = NCH + 4;
  logic [NS-1:0] pin_s1;
  logic [NS-1:0] pin_s2;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1 <= {{(NCH+1){1'b0}}, 3'b111};
      pin_s2 <= {{(NCH+1){1'b0}}, 3'b111};
    end else begin
      pin_s1 <= {direct_channel_inputs_i, fail_force_i, timebase_clk_i,
                 reset_pin_n_i, cs_n_i};
      pin_s2 <= pin_s1;
    end
  end

  logic [NCH-1:0] filt_direct; // filtered direct inputs
  logic           filt_ff;     // filtered fail-force
  logic           filt_rst_n;  // filtered reset pin
  logic           filt_tb;     // filtered timebase clock

  // per-channel symmetric filters
  for (genvar i = 0; i < NCH; i++) begin : g_in
    deglitch #(.N(IN_DGL), .W(24), .SYM(1'b1), .INIT(1'b0)) u_in (
      .clk_i  (clk_i),
      .rst_n_i(rst_n_i),
      .raw_i  (pin_s2[4+i]),
      .filt_o (filt_direct[i])
    );
  end
  deglitch #(.N(IN_DGL), .W(24), .SYM(1'b1), .INIT(1'b0)) u_ff (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .raw_i  (pin_s2[3]),
    .filt_o (filt_ff)
  );
  // falling edge filtered, rising edge passes at once
  deglitch #(.N(RST_DGL_CYC), .W(16), .SYM(1'b0), .INIT(1'b1)) u_rst (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .raw_i  (pin_s2[1]),
    .filt_o (filt_rst_n)
  );
  // a timebase faster than this filter never gets through: seen as failed
  deglitch #(.N(CLK_DGL_CYC), .W(16), .SYM(1'b1), .INIT(1'b0)) u_tb (
    .clk_i  (clk_i),
    .rst_n_i(rst_n_i),
    .raw_i  (pin_s2[2]),
    .filt_o (filt_tb)
  );

  // frame end: chip select seen rising after synchronisation
  logic cs_d;
  logic frame_end;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_d <= 1'b1;
    end else begin
      cs_d <= pin_s2[0];
    end
  end
  assign frame_end = pin_s2[0] && !cs_d;

  // link counters are quiet once chip select is high, so read them directly
  logic len_err;
  logic tog_err;
  logic good_frame;
  logic have_prev;  // a toggle value has been accepted since reset
  logic prev_tog;   // toggle bit of the last accepted message
  assign len_err    = frame_end && (lk_cnt[3:0] != 4'h0);
  assign tog_err    = frame_end && !len_err && have_prev
                      && (lk_shift[TOGGLE_POS] == prev_tog);
  assign good_frame = frame_end && !len_err && !tog_err;

  // remember the toggle bit of accepted messages; sleep forgets it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      have_prev <= 1'b0;
      prev_tog  <= 1'b0;
    end else if (!filt_rst_n) begin
      have_prev <= 1'b0;
    end else if (good_frame) begin
      have_prev <= 1'b1;
      prev_tog  <= lk_shift[TOGGLE_POS];
    end
  end

  // watchdog timer, restarted by good messages and held in sleep
  logic [26:0] wd_cnt;
  logic [26:0] wd_limit;
  logic        wd_expire;
  logic        comm_fault;
  assign wd_limit   = watchdog_period_select_i ? 27'(WD1 - 1) : 27'(WD0 - 1);
  assign wd_expire  = (wd_cnt >= wd_limit);
  assign comm_fault = filt_rst_n && (len_err || tog_err || wd_expire);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wd_cnt <= '0;
    end else if (!filt_rst_n || good_frame || wd_expire) begin
      wd_cnt <= '0;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  // mode control: sleep while reset pin low, fail on any fault or force
  mode_t mode;
  mode_t next_mode;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      MODE_SLEEP:  next_mode = (comm_fault || filt_ff) ? MODE_FAIL : MODE_NORMAL;
      MODE_NORMAL: if (comm_fault || filt_ff) next_mode = MODE_FAIL;
      MODE_FAIL:   if (good_frame && !filt_ff) next_mode = MODE_NORMAL;
      default:     next_mode = MODE_SLEEP; // unused code
    endcase
    if (!filt_rst_n) begin
      next_mode = MODE_SLEEP;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode <= MODE_SLEEP;
    end else begin
      mode <= next_mode;
    end
  end

  // link failure flag: fault sets it, leaving Fail for Normal clears it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link_failure_flag_o <= 1'b0;
    end else if (comm_fault) begin
      link_failure_flag_o <= 1'b1;
    end else if (!filt_rst_n || (mode == MODE_FAIL && next_mode == MODE_NORMAL)) begin
      link_failure_flag_o <= 1'b0;
    end
  end

  // latched host setting channel six; quick status reads decoded
  logic ch6;
  logic qs_read;
  assign qs_read = good_frame && (lk_shift[ADDR_HI:ADDR_LO] == ADDR_QSTAT);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ch6 <= 1'b0;
    end else if (!filt_rst_n) begin
      ch6 <= 1'b0;
    end else if (good_frame && lk_shift[ADDR_HI:ADDR_LO] == ADDR_INPUT) begin
      ch6 <= lk_shift[CH6_POS];
    end
  end

  // slow timebase: cycles since the last filtered rising edge
  logic        tb_d;
  logic [23:0] tb_cnt;
  logic        clk_bad;
  assign clk_bad = (tb_cnt >= 24'(CLK_LOW - 1));
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tb_d   <= 1'b0;
      tb_cnt <= '0;
    end else begin
      tb_d <= filt_tb;
      if (!filt_rst_n || (filt_tb && !tb_d)) begin
        tb_cnt <= '0;
      end else if (!clk_bad) begin
        tb_cnt <= tb_cnt + 1'b1;
      end
    end
  end

  // clock fail latch: the condition wins over a clearing read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_fail_o <= 1'b0;
    end else if (clk_bad) begin
      clock_fail_o <= 1'b1;
    end else if (qs_read) begin
      clock_fail_o <= 1'b0;
    end
  end

  // channel and switch drive outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_out_o           <= '0;
      external_switch_drive_o <= 1'b0;
    end else begin
      unique case (mode)
        MODE_FAIL:   channel_out_o <= filt_direct;
        MODE_NORMAL: channel_out_o <= clock_fail_o ? channel_on_request_i : pwm_i;
        default:     channel_out_o <= '0;
      endcase
      external_switch_drive_o <= (mode == MODE_NORMAL) && ch6;
    end
  end

  // plain status outputs and the data-out enable
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_o                <= MODE_SLEEP;
      filtered_fail_force_o <= 1'b0;
      miso_oe_n_o           <= 1'b1;
    end else begin
      mode_o                <= mode;
      filtered_fail_force_o <= filt_ff;
      miso_oe_n_o           <= pin_s2[0];
    end
  end

  // ---------------- checks ----------------
  fault_to_fail_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    comm_fault |=> mode == MODE_FAIL)
    else $error("link fault did not force fail mode");
  toggle_fault_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (tog_err && filt_rst_n) |=> link_failure_flag_o)
    else $error("repeated toggle bit not flagged");
  wd_timeout_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (filt_rst_n && wd_cnt == wd_limit) |-> comm_fault ##1 (wd_cnt == 27'h000_0000))
    else $error("watchdog timeout not handled");
  len_check_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (frame_end && filt_rst_n && lk_cnt[3:0] != 4'h0) |-> comm_fault)
    else $error("odd frame length not caught");
  flag_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode == MODE_FAIL && next_mode == MODE_FAIL) |=> !$fell(link_failure_flag_o))
    else $error("link failure flag dropped inside fail mode");
  drive_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode != MODE_NORMAL) |=> !external_switch_drive_o)
    else $error("switch drive on outside normal mode");
  fail_outputs_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (mode == MODE_FAIL) |=> channel_out_o == $past(filt_direct))
    else $error("fail mode outputs not from direct inputs");
  force_fail_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (filt_ff && filt_rst_n && mode != MODE_SLEEP) |=> mode == MODE_FAIL ##1 mode_o == MODE_FAIL)
    else $error("fail-force did not force fail mode");
  clk_latch_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (clock_fail_o && (clk_bad || !qs_read)) |=> clock_fail_o)
    else $error("clock fail cleared too early");
endmodule // spi_link_and_input_supervisor

`default_nettype wire

// >>> verification/spi_host_model.sv
// host side of the serial link: a bus master that sends whole frames.
// assumes the device shifts status out on falling link clock edges.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // link toward the device
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_n_i
);
  logic tog;  // toggle bit of the last message that counted
  // link clock stands still low and select idles high between frames
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    tog    = 1'b0;
  end
  // kind 0: good message, 1: toggle repeated, 2: toggle inverted, not counted
  task automatic frame(input int nb, input logic [15:0] w, input int kind,
                       output logic [15:0] r);
    logic t;
    int   b;
    t = (kind == 1) ? tog : ~tog;
    r = 16'h0000;
    cs_n_o = 1'b0;
    for (int i = 0; i < nb; i++) begin
      b = (nb - 1 - i) % 16;  // the last sixteen bits carry the command
      mosi_o = (b == 15) ? t : w[b];
      #62.5 sclk_o = 1'b1;
      // data only counts while the device drives the line
      r[15 - (i % 16)] = (miso_oe_n_i === 1'b0) ? miso_i : 1'bx;
      #62.5 sclk_o = 1'b0;
    end
    #62.5 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;  // a released line does not keep its last level
    if (kind == 0) begin
      tog = t;
    end
    #100;  // idle gap well above four system clocks
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> verification/spi_link_and_input_supervisor_tb.sv
// bench for the serial link and input supervisor, one task per scenario.
// assumes shortened counts: watchdog 2000/8000, filter 20, slow clock 3000.
`timescale 1ns/1ps
`default_nettype none
module spi_link_and_input_supervisor_tb;
  import supervisor_pkg::*;
  logic        clk, rst_n, sclk, cs_n, mosi, miso, miso_oe_n;  // clock and link
  logic        ff, rp, tbclk, sel;    // pins and period select
  logic [3:0]  dir, req, pwm, chan;   // channel inputs and drive
  logic        ext, lff, fff, ckf;    // flags seen
  logic [1:0]  mode;                  // mode seen
  logic [15:0] rx;                    // status word of the last frame
  int          n_errors, checked, cycles;
  int          half = 1000;           // timebase half period in clocks

  spi_link_and_input_supervisor #(.WD0(2000), .WD1(8000), .IN_DGL(20), .CLK_LOW(3000))
  u_spi_link_and_input_supervisor (
    .clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_n_o(miso_oe_n), .fail_force_i(ff),
    .direct_channel_inputs_i(dir), .reset_pin_n_i(rp), .timebase_clk_i(tbclk),
    .watchdog_period_select_i(sel), .channel_on_request_i(req), .pwm_i(pwm),
    .channel_out_o(chan), .external_switch_drive_o(ext), .mode_o(mode),
    .link_failure_flag_o(lff), .filtered_fail_force_o(fff), .clock_fail_o(ckf));

  spi_host_model u_spi_host_model (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_n_i(miso_oe_n));

  // system clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // timebase pin; a short half period is swallowed by its filter
  initial begin
    tbclk = 1'b0;
    forever begin
      repeat (half) @(negedge clk);
      tbclk = ~tbclk;
    end
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one frame, then let the result reach the outputs
  task automatic xf(input int nb, input logic [15:0] w, input int kind);
    u_spi_host_model.frame(nb, w, kind, rx);
    cyc(8);
  endtask
  task automatic done(input string s);
    $display("end of %s", s);
  endtask

  task automatic t_normal();
    xf(16, 16'h0020, 0);
    chk("drive", ext, 1'b1);
    chk("chan", chan, 4'h5);
    chk("addr", rx[14:12], ADDR_DSTAT);
    chk("lff bit", rx[LFF_POS], 1'b0);
    xf(16, 16'h0000, 0);
    chk("drive", ext, 1'b0);
    xf(16, 16'h0020, 0);
    done("normal");
  endtask

  task automatic t_toggle();
    xf(16, 16'h0020, 1);
    chk("mode", mode, MODE_FAIL);
    chk("lff", lff, 1'b1);
    chk("drive", ext, 1'b0);
    dir = 4'h5;
    cyc(10);
    dir = 4'h0;
    cyc(30);
    chk("chan", chan, 4'h0);
    dir = 4'hA;
    cyc(30);
    chk("chan", chan, 4'hA);
    dir = 4'h0;
    cyc(10);
    chk("chan", chan, 4'hA);
    cyc(20);
    chk("chan", chan, 4'h0);
    chk("lff", lff, 1'b1);
    xf(16, 16'h0020, 0);
    chk("lff bit", rx[LFF_POS], 1'b1);
    chk("mode", mode, MODE_NORMAL);
    chk("lff", lff, 1'b0);
    done("toggle");
  endtask

  task automatic t_length();
    int nb[4] = '{15, 17, 31, 32};
    foreach (nb[k]) begin
      xf(nb[k], 16'h0020, (nb[k] % 16 == 0) ? 0 : 2);
      chk("mode", mode, (nb[k] % 16 == 0) ? MODE_NORMAL : MODE_FAIL);
      xf(16, 16'h0020, 0);
    end
    done("length");
  endtask

  task automatic t_wdog();
    for (int s = 0; s < 2; s++) begin
      sel = s[0];
      xf(16, 16'h0020, 0);
      cyc(s == 0 ? 1900 : 7900);
      chk("mode", mode, MODE_NORMAL);
      for (int i = 0; i < 300 && mode !== MODE_FAIL; i++) cyc(1);
      chk("mode", mode, MODE_FAIL);
      xf(16, 16'h0020, 0);
    end
    done("watchdog");
  endtask

  task automatic t_force();
    ff = 1'b1;
    cyc(10);
    ff = 1'b0;
    cyc(30);
    chk("fff", fff, 1'b0);
    ff = 1'b1;
    cyc(18);
    chk("fff", fff, 1'b0);
    cyc(10);
    chk("fff", fff, 1'b1);
    cyc(2);
    chk("mode", mode, MODE_FAIL);
    chk("drive", ext, 1'b0);
    xf(16, 16'h0020, 0);
    chk("ff bit", rx[FF_POS], 1'b1);
    chk("mode", mode, MODE_FAIL);
    ff = 1'b0;
    cyc(30);
    xf(16, 16'h0020, 0);
    chk("mode", mode, MODE_NORMAL);
    done("force");
  endtask

  task automatic t_clock();
    half = 50;
    for (int i = 0; i < 6000 && ckf !== 1'b1; i++) cyc(1);
    chk("ckf", ckf, 1'b1);
    cyc(3);
    chk("chan", chan, 4'h3);
    xf(16, 16'h1000, 0);
    chk("ckf", ckf, 1'b1);
    half = 1000;
    cyc(2500);
    chk("ckf", ckf, 1'b1);
    xf(16, 16'h1000, 0);
    chk("ckf", ckf, 1'b0);
    chk("chan", chan, 4'h5);
    done("clock");
  endtask

  task automatic t_sleep();
    rp = 1'b0;
    cyc(100);
    rp = 1'b1;
    cyc(10);
    chk("mode", mode, MODE_NORMAL);
    rp = 1'b0;
    cyc(2480);
    chk("mode", mode, MODE_NORMAL);
    cyc(40);
    chk("mode", mode, MODE_SLEEP);
    chk("drive", ext, 1'b0);
    rp = 1'b1;
    cyc(6);
    chk("mode", mode, MODE_NORMAL);
    xf(16, 16'h0020, 1);
    chk("mode", mode, MODE_NORMAL);
    done("sleep");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    ff = 1'b0;
    rp = 1'b1;
    sel = 1'b1;
    dir = 4'h0;
    req = 4'h3;
    pwm = 4'h5;
    cyc(10);
    rst_n = 1'b1;
    cyc(6);
    chk("mode", mode, MODE_NORMAL);
    t_normal();
    t_toggle();
    t_length();
    t_wdog();
    t_force();
    t_clock();
    t_sleep();
    stop_test();
  end
endmodule // spi_link_and_input_supervisor_tb
`default_nettype wire
